/* hdl/codec_mode_control.sv */
// Mode control for a stereo codec: serial control words or strap pins.
// Assumes the host holds the shift clock still while the latch is high.
`timescale 1ns/10ps
module codec_mode_control
  import codec_pkg::*;
#(
  parameter int ZERO_RUN_LEN = 65536
) (
  // System
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Three-wire control port
  input  wire logic       control_serial_clock,
  input  wire logic       control_serial_data,
  input  wire logic       control_latch_strobe,
  // Hardware variant straps
  input  wire logic       hardware_variant,
  input  wire logic       adc_sleep_pin_n,
  input  wire logic       dac_sleep_pin_n,
  input  wire logic [1:0] emphasis_pin,
  input  wire logic       word_width_pin,
  // Audio clocks and DAC data
  input  wire logic       bit_clock_in,
  input  wire logic       word_select_clock,
  input  wire logic       dac_data_in,
  // Gain
  output logic [7:0]      left_gain_level,
  output logic [7:0]      right_gain_level,
  output logic            left_muted,
  output logic            right_muted,
  // Converter control
  output logic            codec_reset,
  output logic            adc_sleep,
  output logic            adc_dout_zero,
  output logic            adc_hpf_skip,
  output logic            dac_sleep,
  output dac_out_t        dac_analog_level,
  output emph_t           emphasis_curve_select,
  output logic            soft_silence,
  output logic            adc_to_dac_echo,
  // Format
  output layout_t         audio_word_layout,
  output logic            sample_width_20,
  output justify_t        dac_justify,
  output justify_t        adc_justify,
  output logic            lr_clock_polarity,
  output logic            left_channel_active,
  output logic            zero_run_seen
);

  localparam logic [ZERO_CNT_W-1:0] ZERO_RUN_CNT =
    ZERO_CNT_W'(ZERO_RUN_LEN);

  function automatic logic addr_is(input logic [WORD_BITS-1:0] w,
                                   input reg_addr_t a);
    addr_is = (w[ADDR_HI:ADDR_LO] == a);
  endfunction

  // Pin synchronisers
  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_s;

  assign pins_raw[PIN_LATCH] = control_latch_strobe;
  assign pins_raw[PIN_HW]    = hardware_variant;
  assign pins_raw[PIN_ADC_N] = adc_sleep_pin_n;
  assign pins_raw[PIN_DAC_N] = dac_sleep_pin_n;
  assign pins_raw[PIN_EMPH0] = emphasis_pin[0];
  assign pins_raw[PIN_EMPH1] = emphasis_pin[1];
  assign pins_raw[PIN_WIDTH] = word_width_pin;
  assign pins_raw[PIN_BCK]   = bit_clock_in;
  assign pins_raw[PIN_WS]    = word_select_clock;
  assign pins_raw[PIN_DATA]  = dac_data_in;

  pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pins    (pins_raw),
    .settled (pins_s)
  );

  // Serial link
  control_link_if lnk ();

  serial_shifter u_shift (
    .control_serial_clock (control_serial_clock),
    .control_serial_data  (control_serial_data),
    .lnk                  (lnk.link)
  );

  // Latch capture
  cap_state_t           cap_r;
  cap_state_t           cap_nxt;
  logic                 latch_d_r;
  logic                 clear_r;
  logic                 wr_r;
  logic [WORD_BITS-1:0] word_r;

  always_comb begin
    cap_nxt = cap_r;
    case (cap_r)
      CAP_IDLE: begin
        if (pins_s[PIN_LATCH] && !latch_d_r) begin
          cap_nxt = CAP_TAKE;
        end
      end
      CAP_TAKE: begin
        cap_nxt = CAP_CLEAR;
      end
      CAP_CLEAR: begin
        if (!pins_s[PIN_LATCH]) begin
          cap_nxt = CAP_IDLE;
        end
      end
      default: begin
        cap_nxt = CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_r     <= CAP_IDLE;
      latch_d_r <= 1'b0;
    end else begin
      cap_r     <= cap_nxt;
      latch_d_r <= pins_s[PIN_LATCH];
    end
  end

  // Link counter cleared after each latch and through reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clear_r <= 1'b1;
    end else begin
      clear_r <= (cap_nxt == CAP_CLEAR);
    end
  end
  assign lnk.clear = clear_r;

  // Word taken only if exactly sixteen bits arrived
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r   <= 1'b0;
      word_r <= '0;
    end else begin
      wr_r <= (cap_r == CAP_TAKE) && (lnk.count == COUNT_FULL);
      if (cap_r == CAP_TAKE) begin
        word_r <= lnk.word;
      end
    end
  end

  logic wr_left;
  logic wr_right;
  logic wr_codec;
  logic wr_format;

  assign wr_left   = wr_r && addr_is(word_r, ADDR_LEFT);
  assign wr_right  = wr_r && addr_is(word_r, ADDR_RIGHT);
  assign wr_codec  = wr_r && addr_is(word_r, ADDR_CODEC);
  assign wr_format = wr_r && addr_is(word_r, ADDR_FORMAT);

  // Gain codes: pending data and levels in force
  logic [7:0] left_pend_r;
  logic [7:0] right_pend_r;
  logic [7:0] left_gain_r;
  logic [7:0] right_gain_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_pend_r  <= GAIN_RESET;
      right_pend_r <= GAIN_RESET;
    end else begin
      if (wr_left) begin
        left_pend_r <= word_r[GAIN_HI:0];
      end
      if (wr_right) begin
        right_pend_r <= word_r[GAIN_HI:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_gain_r  <= GAIN_RESET;
      right_gain_r <= GAIN_RESET;
    end else if (wr_left && word_r[APPLY_BIT]) begin
      left_gain_r  <= word_r[GAIN_HI:0];
      right_gain_r <= right_pend_r;
    end else if (wr_right && word_r[APPLY_BIT]) begin
      left_gain_r  <= left_pend_r;
      right_gain_r <= word_r[GAIN_HI:0];
    end
  end

  // Codec control word
  logic  adc_sleep_r;
  logic  hpf_skip_r;
  logic  dac_sleep_r;
  logic  shared_r;
  logic  zero_en_r;
  logic  midscale_r;
  emph_t emph_r;
  logic  soft_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adc_sleep_r <= 1'b0;
      hpf_skip_r  <= 1'b0;
      dac_sleep_r <= 1'b0;
      shared_r    <= 1'b0;
      zero_en_r   <= 1'b0;
      midscale_r  <= 1'b0;
      emph_r      <= EMPH_OFF;
      soft_r      <= 1'b0;
    end else if (wr_codec) begin
      adc_sleep_r <= word_r[ADC_SLEEP_BIT];
      hpf_skip_r  <= word_r[HPF_SKIP_BIT];
      dac_sleep_r <= word_r[DAC_SLEEP_BIT];
      shared_r    <= word_r[SHARED_BIT];
      zero_en_r   <= word_r[ZERO_EN_BIT];
      midscale_r  <= word_r[MIDSCALE_BIT];
      emph_r      <= emph_t'(word_r[EMPH_HI:EMPH_LO]);
      soft_r      <= word_r[SOFT_BIT];
    end
  end

  // Audio format word; reserved bits are ignored
  logic    echo_r;
  layout_t layout_r;
  logic    lrp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      echo_r   <= 1'b0;
      layout_r <= FMT_16_RJ;
      lrp_r    <= 1'b0;
    end else if (wr_format) begin
      echo_r   <= word_r[ECHO_BIT];
      layout_r <= layout_t'(word_r[LAYOUT_HI:LAYOUT_LO]);
      lrp_r    <= word_r[LRP_BIT];
    end
  end

  // Zero-run detector on the DAC input
  logic                  bck_d_r;
  logic                  bck_rise;
  logic [ZERO_CNT_W-1:0] zero_cnt_r;
  logic                  zero_hit;

  assign bck_rise = pins_s[PIN_BCK] && !bck_d_r;
  assign zero_hit = (zero_cnt_r == ZERO_RUN_CNT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bck_d_r <= 1'b0;
    end else begin
      bck_d_r <= pins_s[PIN_BCK];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_cnt_r <= '0;
    end else if (bck_rise) begin
      if (pins_s[PIN_DATA]) begin
        zero_cnt_r <= '0;
      end else if (!zero_hit) begin
        zero_cnt_r <= zero_cnt_r + ZERO_CNT_W'(1);
      end
    end
  end

  // Effective settings, straps win in the hardware variant
  logic     hw;
  logic     adc_off;
  logic     dac_off;
  emph_t    emph_eff;
  logic     wide_eff;
  justify_t dac_just_eff;
  justify_t adc_just_eff;
  dac_out_t dac_state;

  assign hw = pins_s[PIN_HW];

  always_comb begin
    if (hw) begin
      adc_off  = !pins_s[PIN_ADC_N];
      dac_off  = !pins_s[PIN_DAC_N];
      emph_eff = emph_t'({pins_s[PIN_EMPH1], pins_s[PIN_EMPH0]});
      wide_eff = pins_s[PIN_WIDTH];
      dac_just_eff = JUST_RIGHT;
      adc_just_eff = JUST_LEFT;
    end else begin
      adc_off  = adc_sleep_r;
      dac_off  = dac_sleep_r;
      emph_eff = emph_r;
      wide_eff = (layout_r != FMT_16_RJ);
      case (layout_r)
        FMT_16_RJ, FMT_20_RJ: begin
          dac_just_eff = JUST_RIGHT;
          adc_just_eff = JUST_LEFT;
        end
        FMT_20_LJ: begin
          dac_just_eff = JUST_LEFT;
          adc_just_eff = JUST_LEFT;
        end
        default: begin
          dac_just_eff = JUST_I2S;
          adc_just_eff = JUST_I2S;
        end
      endcase
      if (echo_r) begin
        dac_just_eff = JUST_I2S;
      end
    end
  end

  // Output priority: sleep, forced midscale, zero-run disconnect
  always_comb begin
    if (dac_off) begin
      dac_state = DAC_GROUND;
    end else if (!hw && midscale_r) begin
      dac_state = DAC_MIDSCALE;
    end else if (!hw && zero_en_r && zero_hit) begin
      dac_state = DAC_OPEN;
    end else begin
      dac_state = DAC_RUN;
    end
  end

  // Registered gain outputs
  logic [7:0] right_src;
  assign right_src = shared_r ? left_gain_r : right_gain_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_gain_level  <= GAIN_RESET;
      right_gain_level <= GAIN_RESET;
      left_muted       <= 1'b0;
      right_muted      <= 1'b0;
    end else begin
      left_gain_level  <= hw ? GAIN_RESET : left_gain_r;
      right_gain_level <= hw ? GAIN_RESET : right_src;
      left_muted  <= !hw && (left_gain_r == GAIN_MUTE);
      right_muted <= !hw && (right_src == GAIN_MUTE);
    end
  end

  // Registered converter outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      codec_reset           <= 1'b0;
      adc_sleep             <= 1'b0;
      adc_dout_zero         <= 1'b0;
      adc_hpf_skip          <= 1'b0;
      dac_sleep             <= 1'b0;
      dac_analog_level      <= DAC_RUN;
      emphasis_curve_select <= EMPH_OFF;
      soft_silence          <= 1'b0;
      adc_to_dac_echo       <= 1'b0;
      zero_run_seen         <= 1'b0;
    end else begin
      codec_reset   <= hw && adc_off && dac_off;
      adc_sleep     <= adc_off;
      adc_dout_zero <= adc_off;
      adc_hpf_skip  <= !hw && hpf_skip_r;
      dac_sleep     <= dac_off;
      dac_analog_level      <= dac_state;
      emphasis_curve_select <= emph_eff;
      soft_silence          <= !hw && soft_r;
      adc_to_dac_echo       <= !hw && echo_r;
      zero_run_seen         <= zero_hit;
    end
  end

  // Registered format outputs
  logic left_level;
  assign left_level = (!hw && layout_r == FMT_20_I2S) ? 1'b0 : !lrp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      audio_word_layout   <= FMT_16_RJ;
      sample_width_20     <= 1'b0;
      dac_justify         <= JUST_RIGHT;
      adc_justify         <= JUST_LEFT;
      lr_clock_polarity   <= 1'b0;
      left_channel_active <= 1'b0;
    end else begin
      audio_word_layout <= hw ? (wide_eff ? FMT_20_RJ : FMT_16_RJ)
                              : layout_r;
      sample_width_20   <= wide_eff;
      dac_justify       <= dac_just_eff;
      adc_justify       <= adc_just_eff;
      lr_clock_polarity <= !hw && lrp_r;
      left_channel_active <=
        (pins_s[PIN_WS] == (hw ? 1'b1 : left_level));
    end
  end

endmodule

/* hdl/codec_pkg.sv */
// Constants, field layout and enumerations for the codec mode control.
// Assumes control words arrive MSB first on a three-wire serial port.
// Function
// - Address bits pick left, right, control, format
// - Load bit updates both channel levels together
// - Gain code, FFh default, 00h full mute
// - ADC sleep stops ADC, output held zero
// - HPF skip bypasses ADC high-pass filter
// - DAC sleep stops DAC, output at ground
// - Shared mode: left data drives both channels
// - Zero run of 65536 bit clocks disconnects
// - Forced midscale holds bipolar zero, keeps registers
// - Emphasis field: 44.1k, off, 48k, 32k
// - Soft silence mutes both channels in filter
// - Echo loops ADC to DAC in I2S
// - Layout field picks one of four formats
// - Word clock polarity, formats 0 to 2
// - Hardware sleep pins decode power-down and reset
// - Hardware emphasis pins decode like the field
// - Width pin picks 16 or 20 bits
// - Shift clock, data, latch driven by host
// - Address 00 holds left load and code
package codec_pkg;

  localparam int WORD_BITS  = 16;
  localparam int ADDR_HI    = 10;
  localparam int ADDR_LO    = 9;
  localparam int APPLY_BIT  = 8;
  localparam int GAIN_HI    = 7;
  localparam int ADC_SLEEP_BIT = 8;
  localparam int HPF_SKIP_BIT  = 7;
  localparam int DAC_SLEEP_BIT = 6;
  localparam int SHARED_BIT    = 5;
  localparam int ZERO_EN_BIT   = 4;
  localparam int MIDSCALE_BIT  = 3;
  localparam int EMPH_HI       = 2;
  localparam int EMPH_LO       = 1;
  localparam int SOFT_BIT      = 0;
  localparam int ECHO_BIT      = 5;
  localparam int LAYOUT_HI     = 3;
  localparam int LAYOUT_LO     = 2;
  localparam int LRP_BIT       = 1;
  localparam int CNT_W         = 5;
  localparam int ZERO_CNT_W    = 17;

  localparam logic [7:0]       GAIN_RESET = 8'hFF;
  localparam logic [7:0]       GAIN_MUTE  = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] COUNT_SAT  = 5'h11;

  // Pin positions in the synchroniser vector
  localparam int PIN_LATCH = 0;
  localparam int PIN_HW    = 1;
  localparam int PIN_ADC_N = 2;
  localparam int PIN_DAC_N = 3;
  localparam int PIN_EMPH0 = 4;
  localparam int PIN_EMPH1 = 5;
  localparam int PIN_WIDTH = 6;
  localparam int PIN_BCK   = 7;
  localparam int PIN_WS    = 8;
  localparam int PIN_DATA  = 9;
  localparam int PIN_COUNT = 10;

  typedef enum logic [1:0] {
    ADDR_LEFT   = 2'b00,
    ADDR_RIGHT  = 2'b01,
    ADDR_CODEC  = 2'b10,
    ADDR_FORMAT = 2'b11
  } reg_addr_t;

  typedef enum logic [1:0] {
    EMPH_44K1 = 2'b00,
    EMPH_OFF  = 2'b01,
    EMPH_48K  = 2'b10,
    EMPH_32K  = 2'b11
  } emph_t;

  typedef enum logic [1:0] {
    FMT_16_RJ  = 2'b00,
    FMT_20_RJ  = 2'b01,
    FMT_20_LJ  = 2'b10,
    FMT_20_I2S = 2'b11
  } layout_t;

  typedef enum logic [1:0] {
    JUST_RIGHT = 2'b00,
    JUST_LEFT  = 2'b01,
    JUST_I2S   = 2'b10
  } justify_t;

  typedef enum logic [1:0] {
    DAC_RUN      = 2'b00,
    DAC_GROUND   = 2'b01,
    DAC_MIDSCALE = 2'b10,
    DAC_OPEN     = 2'b11
  } dac_out_t;

  typedef enum logic [1:0] {
    CAP_IDLE  = 2'b00,
    CAP_TAKE  = 2'b01,
    CAP_CLEAR = 2'b10
  } cap_state_t;

endpackage

/* hdl/control_link_if.sv */
// Carries the shifted control word between link and system domains.
// Word and count are static while the shift clock stands still.
`timescale 1ns/10ps
interface control_link_if;
  import codec_pkg::*;
  logic [WORD_BITS-1:0] word;
  logic [CNT_W-1:0]     count;
  logic                 clear;
  modport link (output word, output count, input clear);
  modport core (input word, input count, output clear);
endinterface

/* hdl/pin_sync.sv */
// Three-flop pin synchroniser; a bit changes once flops two and three agree.
// Assumes inputs change slower than a quarter of the system clock rate.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // System
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins in, settled levels out
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] settled
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          settled[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          settled[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

/* hdl/serial_shifter.sv */
// Shifts control bits in on the host shift clock and counts them.
// Clear comes from the system domain and only falls while the clock idles.
`timescale 1ns/10ps
module serial_shifter
  import codec_pkg::*;
(
  // Link clock and data
  input  wire logic   control_serial_clock,
  input  wire logic   control_serial_data,
  // To system domain
  control_link_if.link lnk
);
  always_ff @(posedge control_serial_clock or posedge lnk.clear) begin
    if (lnk.clear) begin
      lnk.count <= '0;
    end else if (lnk.count != COUNT_SAT) begin
      lnk.count <= lnk.count + CNT_W'(1);
    end
  end

  // MSB first into the low end
  always_ff @(posedge control_serial_clock or posedge lnk.clear) begin
    if (lnk.clear) begin
      lnk.word <= '0;
    end else begin
      lnk.word <= {lnk.word[WORD_BITS-2:0], control_serial_data};
    end
  end
endmodule

/* verification/control_host.sv */
// Host model driving the three-wire control port of the codec.
// Assumes the device takes data on the shift clock rising edge.
`timescale 1ns/10ps
module control_host (
  // Three-wire control port
  output logic control_serial_clock,
  output logic control_serial_data,
  output logic control_latch_strobe
);
  initial begin
    control_serial_clock = 1'b0;
    control_serial_data  = 1'b1;
    control_latch_strobe = 1'b0;
  end

  // Frame of n bits, MSB first; shift clock idles outside it
  task automatic send(input logic [10:0] body, input int n);
    logic [16:0] w;
    w = {6'h00, body};
    #37;
    for (int i = n - 1; i >= 0; i--) begin
      control_serial_data = w[i];
      #80 control_serial_clock = 1'b1;
      #80 control_serial_clock = 1'b0;
    end
    // Released data line shows the inverse, never a stale bit
    control_serial_data = ~control_serial_data;
    #200 control_latch_strobe = 1'b1;
    #1000 control_latch_strobe = 1'b0;
    #900;
  endtask
endmodule

/* verification/codec_mode_control_chk.sv */
// Concurrent checks on the codec mode control ports.
// Assumes one system clock with synchronous active-low reset.
`timescale 1ns/10ps
module codec_mode_control_chk
  import codec_pkg::*;
(
  // System
  input wire logic       clk,
  input wire logic       rst_n,
  // Control inputs
  input wire logic       control_latch_strobe,
  input wire logic       hardware_variant,
  input wire logic       adc_sleep_pin_n,
  input wire logic       dac_sleep_pin_n,
  input wire logic [1:0] emphasis_pin,
  input wire logic       word_width_pin,
  // Outputs watched
  input wire logic [7:0] left_gain_level,
  input wire logic       left_muted,
  input wire logic       codec_reset,
  input wire logic       adc_sleep,
  input wire logic       adc_dout_zero,
  input wire logic       adc_hpf_skip,
  input wire logic       dac_sleep,
  input dac_out_t        dac_analog_level,
  input emph_t           emphasis_curve_select,
  input wire logic       soft_silence,
  input wire logic       adc_to_dac_echo,
  input layout_t         audio_word_layout,
  input wire logic       sample_width_20,
  input justify_t        dac_justify,
  input justify_t        adc_justify,
  input wire logic       zero_run_seen
);
  logic [3:0] quiet_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Cycles since the last latch or strap control
  always_ff @(posedge clk) begin
    if (!rst_n || control_latch_strobe || hardware_variant) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  mute_flag_a: assert property (
    left_muted == (left_gain_level == 8'h00))
    else $error("left mute flag disagrees with gain code");
  adc_zero_a: assert property (adc_dout_zero == adc_sleep)
    else $error("adc output not held zero in sleep");
  dac_ground_a: assert property (
    dac_sleep |-> dac_analog_level == DAC_GROUND)
    else $error("dac not grounded in sleep");
  open_needs_zero_a: assert property (
    dac_analog_level == DAC_OPEN |-> zero_run_seen)
    else $error("output opened without a zero run");
  echo_i2s_a: assert property (
    adc_to_dac_echo |-> dac_justify == JUST_I2S)
    else $error("echo without i2s dac layout");
  hw_reset_a: assert property (
    (hardware_variant && !adc_sleep_pin_n && !dac_sleep_pin_n) [*8]
    |=> codec_reset && adc_sleep && dac_sleep)
    else $error("both sleep pins low without reset");
  hw_emph_a: assert property (
    (hardware_variant && $stable(emphasis_pin)) [*8]
    |=> emphasis_curve_select == $past(emphasis_pin))
    else $error("emphasis does not follow pins");
  hw_width_a: assert property (
    (hardware_variant && $stable(word_width_pin)) [*8]
    |=> sample_width_20 == $past(word_width_pin)
        && dac_justify == JUST_RIGHT
        && adc_justify == JUST_LEFT)
    else $error("width pin layout wrong");
  latch_only_a: assert property (
    !$stable({left_gain_level, adc_hpf_skip, soft_silence,
              emphasis_curve_select, audio_word_layout})
    |-> quiet_r < 4'hC)
    else $error("settings changed without a latched word");

  cover property (dac_analog_level == DAC_OPEN);
  cover property (codec_reset);
  cover property (adc_to_dac_echo && audio_word_layout == FMT_20_LJ);
endmodule

bind codec_mode_control codec_mode_control_chk chk_u (.*);

/* verification/codec_mode_control_test.sv */
// Self-checking bench for the codec mode control block.
// Assumes control_host frames every control word on the link.
`timescale 1ns/10ps
module codec_mode_control_test;
  import codec_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic control_serial_clock, control_serial_data, control_latch_strobe;
  logic hardware_variant = 1'b0;
  logic adc_sleep_pin_n = 1'b1;
  logic dac_sleep_pin_n = 1'b1;
  logic [1:0] emphasis_pin = 2'h1;
  logic word_width_pin = 1'b0;
  logic bit_clock_in = 1'b0;
  logic word_select_clock = 1'b0;
  logic dac_data_in = 1'b1;
  logic [7:0] left_gain_level, right_gain_level;
  logic left_muted, right_muted, codec_reset, adc_sleep, adc_dout_zero;
  logic adc_hpf_skip, dac_sleep, soft_silence, adc_to_dac_echo;
  logic sample_width_20, lr_clock_polarity, left_channel_active;
  logic zero_run_seen;
  dac_out_t dac_analog_level;
  emph_t emphasis_curve_select;
  layout_t audio_word_layout;
  justify_t dac_justify, adc_justify;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h6ace_0719;
  logic [7:0] pl = 8'hFF, pr = 8'hFF, al = 8'hFF, ar = 8'hFF;
  logic [8:0] cr = 9'h002;
  logic [8:0] fr = 9'h000;
  logic zr = 1'b0;
  logic [31:0] r;

  always #50 clk = ~clk;

  codec_mode_control #(.ZERO_RUN_LEN(16)) dut_u (.*);
  control_host host_u (.*);

  function automatic dac_out_t lvl_f(logic [8:0] c, logic z);
    if (c[6]) return DAC_GROUND;
    if (c[3]) return DAC_MIDSCALE;
    if (c[4] && z) return DAC_OPEN;
    return DAC_RUN;
  endfunction

  function automatic justify_t dj_f(logic [8:0] f);
    if (f[5] || f[3:2] == 2'b11) return JUST_I2S;
    return (f[3:2] == 2'b10) ? JUST_LEFT : JUST_RIGHT;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic verify;
    logic [7:0] eg;
    eg = cr[5] ? al : ar;
    repeat (6) @(negedge clk);
    chk(left_gain_level, al);
    chk(right_gain_level, eg);
    chk(right_muted, eg == 8'h00);
    chk(adc_sleep, cr[8]);
    chk(adc_hpf_skip, cr[7]);
    chk(dac_sleep, cr[6]);
    chk(dac_analog_level, lvl_f(cr, zr));
    chk(emphasis_curve_select, cr[2:1]);
    chk(soft_silence, cr[0]);
    chk(adc_to_dac_echo, fr[5]);
    chk(audio_word_layout, fr[3:2]);
    chk(sample_width_20, fr[3:2] != 2'b00);
    chk(dac_justify, dj_f(fr));
    chk(adc_justify, fr[3:2] == 2'b11 ? JUST_I2S : JUST_LEFT);
    chk(lr_clock_polarity, fr[1]);
    chk(left_channel_active, fr[3:2] == 2'b11 ? !word_select_clock
        : word_select_clock ^ fr[1]);
  endtask

  task automatic wr(input logic [1:0] a, input logic [8:0] b);
    host_u.send({a, b}, 16);
    case (a)
      2'b00: begin
        pl = b[7:0];
        if (b[8]) begin
          al = b[7:0];
          ar = pr;
        end
      end
      2'b01: begin
        pr = b[7:0];
        if (b[8]) begin
          ar = b[7:0];
          al = pl;
        end
      end
      2'b10: cr = b;
      default: fr = b;
    endcase
    verify();
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(negedge clk);
      bit_clock_in = 1'b1;
      repeat (4) @(negedge clk);
      bit_clock_in = 1'b0;
    end
  endtask

  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    verify();
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(2'b10, {r[8:3], i[1:0], r[0]});
      repeat (2) begin
        r = $random(seed);
        wr({1'b0, r[9]}, r[8:0]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      @(negedge clk);
      word_select_clock = r[2];
      wr(2'b11, {3'h0, i[2], 1'b0, i[1:0], r[1], 1'b0});
    end
    // Short and long frames must leave everything alone
    for (int n = 15; n <= 17; n += 2) begin
      host_u.send({2'b10, 9'h1FF}, n);
      verify();
    end
    wr(2'b10, 9'h010);
    dac_data_in = 1'b0;
    tick(20);
    zr = 1'b1;
    verify();
    chk(zero_run_seen, 1'b1);
    dac_data_in = 1'b1;
    tick(1);
    zr = 1'b0;
    verify();
    chk(zero_run_seen, 1'b0);
    hardware_variant = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      {adc_sleep_pin_n, dac_sleep_pin_n, emphasis_pin} = i[3:0];
      word_width_pin = r[0];
      repeat (10) @(negedge clk);
      chk(codec_reset, !i[3] && !i[2]);
      chk(adc_sleep, !i[3]);
      chk(dac_sleep, !i[2]);
      chk(emphasis_curve_select, i[1:0]);
      chk(sample_width_20, word_width_pin);
      chk(left_gain_level, 8'hFF);
    end
    hardware_variant = 1'b0;
    {adc_sleep_pin_n, dac_sleep_pin_n} = 2'b11;
    verify();
    print_verdict();
  end

  // Whole run needs well under a third of this span
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end
endmodule
